/* File: bench/host_model.sv */
`timescale 1ns/1ps
module host_model (
	// Clock
	input  wire       clk_sys,
	// Register port
	output reg        burst_active,
	output reg  [7:0] reg_addr,
	output reg        reg_rd,
	output reg        reg_wr,
	output reg  [7:0] reg_wdata
);
	initial begin
		{burst_active, reg_addr, reg_rd, reg_wr, reg_wdata} = 0;
	end
	task burst(input bit on);
		burst_active = on;
	endtask
	// Idle cycle between bytes; address inverted so a stale one is never reused
	task xfer(input bit w, input [7:0] a, input [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd = !w;
		reg_wr = w;
		reg_wdata = d;
		@(negedge clk_sys);
		{reg_rd, reg_wr} = 0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
endmodule

/* File: bench/sensor_data_time_regs_sva.sv */
`timescale 1ns/1ps
module sensor_data_time_regs_sva (
	// Clock, reset, enable
	input wire        clk_sys,
	input wire        rst_b,
	input wire        clk_en,
	// Sample strobes
	input wire        aux_sample_valid,
	input wire        accel_sample_valid,
	// Host port
	input wire [7:0]  reg_addr,
	input wire        reg_rd,
	input wire        reg_wr,
	input wire [7:0]  reg_rdata,
	input wire        reg_rvalid,
	input wire        reg_wack,
	// Status
	input wire        accel_drdy,
	input wire        aux_drdy,
	input wire [23:0] sensor_time
);
	wire rd = clk_en && reg_rd;
	wire acc = rd && reg_addr >= 8'h12 && reg_addr <= 8'h17;
	wire aux = rd && reg_addr[7:1] == 7'h08;
	wire lo = rd && reg_addr >= 8'h10 && reg_addr <= 8'h16 && !reg_addr[0];
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	sequence s_acc; acc && !accel_sample_valid; endsequence
	sequence s_aux; aux && !aux_sample_valid; endsequence
	property p_lo; lo |=> reg_rvalid && reg_rdata[3:0] == 4'h0; endproperty
	property p_acc; s_acc |=> !accel_drdy; endproperty
	property p_aux; s_aux |=> !aux_drdy; endproperty
	property p_set; clk_en && accel_sample_valid |=> accel_drdy; endproperty
	property p_wr; clk_en && reg_wr && !reg_rd && !accel_sample_valid |=> $stable(accel_drdy);
	endproperty
	// Reset edge excluded: the count drops to zero there
	property p_tm; $past(rst_b) && !$stable(sensor_time) |->
		sensor_time == $past(sensor_time) + 24'h1; endproperty
	property p_en; !clk_en |=> $stable(sensor_time); endproperty
	property p_rst; !$past(rst_b) |-> sensor_time == 24'h0 && !accel_drdy && !aux_drdy;
	endproperty
	a_lo: assert property (p_lo) else $error("low nibble set");
	a_acc: assert property (p_acc) else $error("accel flag kept");
	a_aux: assert property (p_aux) else $error("aux flag kept");
	a_set: assert property (p_set) else $error("accel flag not set");
	a_wr: assert property (p_wr) else $error("write changed flag");
	a_tm: assert property (p_tm) else $error("time jump");
	a_en: assert property (p_en) else $error("time ran while disabled");
	a_rst: assert property (p_rst) else $error("reset value");
	property p_aset; clk_en && aux_sample_valid |=> aux_drdy; endproperty
	property p_wack; clk_en && reg_wr |=> reg_wack; endproperty
	property p_rv; rd |=> reg_rvalid; endproperty
	a_aset: assert property (p_aset) else $error("aux flag not set");
	a_wack: assert property (p_wack) else $error("write not acknowledged");
	a_rv: assert property (p_rv) else $error("read not answered");
endmodule
bind sensor_data_time_regs sensor_data_time_regs_sva chk (
	.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
	.aux_sample_valid(aux_sample_valid), .accel_sample_valid(accel_sample_valid),
	.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
	.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_wack(reg_wack),
	.accel_drdy(accel_drdy), .aux_drdy(aux_drdy), .sensor_time(sensor_time)
);

/* File: bench/sensor_data_time_regs_test.sv */
`timescale 1ns/1ps
module sensor_data_time_regs_test;
	// Clock, reset, samples
	reg          clk_sys = 0;
	reg          rst_b = 0;
	reg          clk_en = 1;
	reg          aux_sample_valid = 0;
	reg          accel_sample_valid = 0;
	reg   [11:0] smp [4];
	// Host port and status
	wire         burst_active, reg_rd, reg_wr, reg_rvalid, reg_wack, accel_drdy, aux_drdy;
	wire  [7:0]  reg_addr, reg_wdata, reg_rdata;
	wire  [23:0] sensor_time;
	int          fails = 0;
	int          n_checks = 0;
	int          n;
	logic [7:0]  expq [$];
	logic [7:0]  old;
	bit   [31:0] seed = 83;
	always #12.5 clk_sys = ~clk_sys;
	sensor_data_time_regs DUT (
		.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
		.aux_fourth_sample(smp[0]), .aux_sample_valid(aux_sample_valid),
		.accel_x_sample(smp[1]), .accel_y_sample(smp[2]), .accel_z_sample(smp[3]),
		.accel_sample_valid(accel_sample_valid), .burst_active(burst_active),
		.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_wack(reg_wack),
		.accel_drdy(accel_drdy), .aux_drdy(aux_drdy), .sensor_time(sensor_time));
	host_model host (.clk_sys(clk_sys), .burst_active(burst_active), .reg_addr(reg_addr),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata));
	function automatic bit [31:0] xs(input bit [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	task check(input string nm, input logic [23:0] s, input logic [23:0] e);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s exp %h got %h", nm, e, s);
		end
	endtask
	task rd(input [7:0] a, input [7:0] e);
		expq.push_back(e);
		host.xfer(0, a, 8'h00);
	endtask
	task load;
		@(negedge clk_sys);
		foreach (smp[k]) begin
			seed = xs(seed);
			smp[k] = seed[11:0];
		end
		{aux_sample_valid, accel_sample_valid} = 2'h3;
		@(negedge clk_sys);
		{aux_sample_valid, accel_sample_valid} = 2'h0;
		@(negedge clk_sys);
	endtask
	task test_done;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Sampled mid-cycle so the registered answer has settled
	always @(negedge clk_sys) if (reg_rvalid === 1'b1) begin
		if (expq.size() == 0) check("stray", 1, 0);
		else check("rdata", reg_rdata, expq.pop_front());
	end
	initial begin
		foreach (smp[k]) smp[k] = 12'h000;
		repeat (3) @(negedge clk_sys);
		rst_b = 1;
		for (int i = 0; i < 11; i++) rd(8'(8'h10 + i), 8'h00);
		$display("reset done");
		repeat (4) begin
			load;
			check("accel_drdy", accel_drdy, 1);
			check("aux_drdy", aux_drdy, 1);
			for (int k = 0; k < 4; k++) begin
				rd(8'(8'h10 + 2 * k), {smp[k][3:0], 4'h0});
				rd(8'(8'h11 + 2 * k), smp[k][11:4]);
			end
			@(negedge clk_sys);
			check("accel_drdy", accel_drdy, 0);
			check("aux_drdy", aux_drdy, 0);
		end
		host.xfer(1, 8'h13, ~smp[1][11:4]);
		check("reg_wack", reg_wack, 1);
		rd(8'h13, smp[1][11:4]);
		rd(8'h20, 8'h00);
		$display("data done");
		host.burst(1);
		old = smp[1][11:4];
		rd(8'h12, {smp[1][3:0], 4'h0});
		load;
		rd(8'h13, old);
		host.burst(0);
		repeat (2) @(negedge clk_sys);
		rd(8'h13, smp[1][11:4]);
		$display("freeze done");
		rst_b = 0;
		repeat (3) @(negedge clk_sys);
		rst_b = 1;
		clk_en = 0;
		// Stalled cycles must not advance the time base
		repeat (100) @(negedge clk_sys);
		clk_en = 1;
		repeat (1600) @(negedge clk_sys);
		rd(8'h18, 8'h01);
		rd(8'h19, 8'h00);
		rd(8'h1a, 8'h00);
		for (n = 0; sensor_time !== 24'h2 && n < 4000; n++) @(negedge clk_sys);
		for (n = 0; sensor_time === 24'h2 && n < 4000; n++) @(negedge clk_sys);
		check("tick", n == 1562 || n == 1563, 1);
		check("pending", expq.size(), 0);
		$display("time done");
		test_done;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		test_done;
	end
endmodule

/* File: hw/sensor_data_time_consts.vh */
`ifndef SENSOR_DATA_TIME_CONSTS_VH
`define SENSOR_DATA_TIME_CONSTS_VH

// Register byte offsets
`define OFS_AUX_FOURTH_LOW   8'h10
`define OFS_AUX_FOURTH_HIGH  8'h11
`define OFS_ACCEL_X_LOW      8'h12
`define OFS_ACCEL_X_HIGH     8'h13
`define OFS_ACCEL_Y_LOW      8'h14
`define OFS_ACCEL_Y_HIGH     8'h15
`define OFS_ACCEL_Z_LOW      8'h16
`define OFS_ACCEL_Z_HIGH     8'h17
`define OFS_TIME_BYTE0       8'h18
`define OFS_TIME_BYTE1       8'h19
`define OFS_TIME_BYTE2       8'h1a

// Bank geometry
`define BANK_FIRST           8'h10
`define BANK_LAST            8'h1a
`define BANK_BYTES           11
`define BANK_IDX_W           4

// Field layout
`define SAMPLE_W             12
`define LOW_NIB_POS          4
`define RESERVED_NIB         4'h0
`define RESET_BYTE           8'h00
`define TIME_W               24

// Timing: time counter step and system clock period, in picoseconds
`define TIME_LSB_PS          27'h2540be4
`define CLK_PERIOD_PS        27'h61a8
`define TICK_ACC_W           27

`endif

/* File: hw/sensor_data_time_regs.v */
// Behaviour
// - Offset 0x10 shows the fourth auxiliary channel bits 3..0 in bits 7..4, zeros below, reset 0.
// - Offset 0x11 shows fourth auxiliary channel bits 11..4, reset 0.
// - Offset 0x12 shows X acceleration bits 3..0 in bits 7..4, low nibble zero, reset 0.
// - Offset 0x13 shows X acceleration bits 11..4, reset 0.
// - Offset 0x14 shows Y acceleration bits 3..0 in bits 7..4, low nibble zero, reset 0.
// - Offset 0x15 shows Y acceleration bits 11..4, reset 0.
// - Offset 0x16 shows Z acceleration bits 3..0 in bits 7..4, low nibble zero, reset 0.
// - Offset 0x17 shows Z acceleration bits 11..4, reset 0.
// - Offset 0x18 shows time counter bits 7..0, one count per 39.0625 us, reset 0.
// - Offset 0x19 shows time counter bits 15..8, one step per 10 ms, reset 0.
// - Offset 0x1a shows time counter bits 23..16, one step per 2.56 s.
// - A host read of any accelerometer data byte clears the accelerometer ready flag.
// - A host read of any auxiliary data byte clears the auxiliary ready flag.
`timescale 1ns/1ps
`include "sensor_data_time_consts.vh"
module sensor_data_time_regs #(
	parameter SAMPLE_W = `SAMPLE_W,
	parameter TIME_W   = `TIME_W
) (
	// Clock, reset, enable
	input  wire                clk_sys,
	input  wire                rst_b,
	input  wire                clk_en,
	// Auxiliary sample input
	input  wire [SAMPLE_W-1:0] aux_fourth_sample,
	input  wire                aux_sample_valid,
	// Accelerometer sample input
	input  wire [SAMPLE_W-1:0] accel_x_sample,
	input  wire [SAMPLE_W-1:0] accel_y_sample,
	input  wire [SAMPLE_W-1:0] accel_z_sample,
	input  wire                accel_sample_valid,
	// Host register port
	input  wire                burst_active,
	input  wire [7:0]          reg_addr,
	input  wire                reg_rd,
	input  wire                reg_wr,
	input  wire [7:0]          reg_wdata,
	output reg  [7:0]          reg_rdata,
	output reg                 reg_rvalid,
	output reg                 reg_wack,
	// Status toward neighbouring logic
	output wire                accel_drdy,
	output wire                aux_drdy,
	output wire [TIME_W-1:0]   sensor_time
);

	localparam NBYTES = `BANK_BYTES;
	localparam IDX_W  = `BANK_IDX_W;
	localparam ACC_W  = `TICK_ACC_W;

	// Step of the time base, derived from the step time and the clock period
	localparam [ACC_W-1:0] TICK_LIMIT = `TIME_LSB_PS;
	localparam [ACC_W-1:0] TICK_STEP  = `CLK_PERIOD_PS;

	// Latched samples; lane 0 auxiliary, lanes 1 to 3 X, Y, Z
	localparam NCHAN = 4;
	wire [NCHAN*SAMPLE_W-1:0] chan_in;
	wire [NCHAN-1:0]          chan_stb;
	reg  [NCHAN*SAMPLE_W-1:0] chan_r;
	wire [SAMPLE_W-1:0]       aux_smp;
	wire [SAMPLE_W-1:0]       acc_x_smp;
	wire [SAMPLE_W-1:0]       acc_y_smp;
	wire [SAMPLE_W-1:0]       acc_z_smp;

	// Time base
	reg  [ACC_W-1:0]    tick_acc_r;
	reg  [ACC_W-1:0]    tick_acc_nxt;
	reg                 tick;
	reg  [TIME_W-1:0]   time_r;
	// Counter is built from byte lanes, so the width must be whole bytes
	localparam TIME_LANES = TIME_W / 8;
	wire [TIME_LANES-1:0] lane_cy;

	// Ready flags
	reg                 acc_drdy_r;
	reg                 acc_drdy_nxt;
	reg                 aux_drdy_r;
	reg                 aux_drdy_nxt;

	// Address decode
	wire                in_bank;
	wire [7:0]          addr_off;
	wire [IDX_W-1:0]    bank_idx;
	wire                rd_accel;
	wire                rd_aux;
	wire                bank_rd;

	// Bank contents
	wire [NBYTES*8-1:0] live_bytes;
	wire [7:0]          bank_rdata;
	reg                 rd_in_bank_r;

	assign addr_off = reg_addr - `BANK_FIRST;
	assign bank_idx = addr_off[IDX_W-1:0];
	assign in_bank  = (reg_addr >= `BANK_FIRST) && (reg_addr <= `BANK_LAST);
	assign bank_rd  = reg_rd && in_bank;

	assign rd_aux   = reg_rd && ((reg_addr == `OFS_AUX_FOURTH_LOW) ||
	                             (reg_addr == `OFS_AUX_FOURTH_HIGH));
	assign rd_accel = reg_rd && (reg_addr >= `OFS_ACCEL_X_LOW) &&
	                  (reg_addr <= `OFS_ACCEL_Z_HIGH);

	// Sample capture; a new sample lands only with its strobe.
	// Axes share one strobe so X, Y and Z always come from one sample
	assign chan_in  = {accel_z_sample, accel_y_sample, accel_x_sample, aux_fourth_sample};
	assign chan_stb = {{3{accel_sample_valid}}, aux_sample_valid};

	genvar c;
	generate
		for (c = 0; c < NCHAN; c = c + 1) begin : g_chan
			always @(posedge clk_sys) begin
				if (!rst_b) begin
					chan_r[c*SAMPLE_W +: SAMPLE_W] <= {SAMPLE_W{1'b0}};
				end else if (clk_en && chan_stb[c]) begin
					chan_r[c*SAMPLE_W +: SAMPLE_W] <= chan_in[c*SAMPLE_W +: SAMPLE_W];
				end
			end
		end
	endgenerate

	assign aux_smp   = chan_r[0*SAMPLE_W +: SAMPLE_W];
	assign acc_x_smp = chan_r[1*SAMPLE_W +: SAMPLE_W];
	assign acc_y_smp = chan_r[2*SAMPLE_W +: SAMPLE_W];
	assign acc_z_smp = chan_r[3*SAMPLE_W +: SAMPLE_W];

	// Fractional accumulator: the step is 1562.5 clocks, so a plain
	// divider would drift; adding the period in picoseconds stays exact
	always @* begin
		tick_acc_nxt = tick_acc_r + TICK_STEP;
		tick         = 1'b0;
		if (tick_acc_nxt >= TICK_LIMIT) begin
			tick_acc_nxt = tick_acc_nxt - TICK_LIMIT;
			tick         = 1'b1;
		end
	end

	always @(posedge clk_sys) begin
		if (!rst_b) begin
			tick_acc_r <= {ACC_W{1'b0}};
		end else if (clk_en) begin
			tick_acc_r <= tick_acc_nxt;
		end
	end

	// Time counter in byte lanes; a lane steps on a tick when every lower bit is one.
	// Wraps silently after the top lane
	assign lane_cy[0] = tick;

	genvar b;
	generate
		for (b = 0; b < TIME_LANES; b = b + 1) begin : g_time_lane
			if (b < TIME_LANES - 1) begin : g_carry
				assign lane_cy[b+1] = lane_cy[b] && (&time_r[b*8 +: 8]);
			end
			always @(posedge clk_sys) begin
				if (!rst_b) begin
					time_r[b*8 +: 8] <= 8'h00;
				end else if (clk_en && lane_cy[b]) begin
					time_r[b*8 +: 8] <= time_r[b*8 +: 8] + 8'h01;
				end
			end
		end
	endgenerate

	assign sensor_time = time_r;

	// Ready flags: a new sample in the clearing cycle wins over the clear
	always @* begin
		acc_drdy_nxt = acc_drdy_r;
		if (rd_accel) begin
			acc_drdy_nxt = 1'b0;
		end
		if (accel_sample_valid) begin
			acc_drdy_nxt = 1'b1;
		end
	end

	always @* begin
		aux_drdy_nxt = aux_drdy_r;
		if (rd_aux) begin
			aux_drdy_nxt = 1'b0;
		end
		if (aux_sample_valid) begin
			aux_drdy_nxt = 1'b1;
		end
	end

	always @(posedge clk_sys) begin
		if (!rst_b) begin
			acc_drdy_r <= 1'b0;
			aux_drdy_r <= 1'b0;
		end else if (clk_en) begin
			acc_drdy_r <= acc_drdy_nxt;
			aux_drdy_r <= aux_drdy_nxt;
		end
	end

	assign accel_drdy = acc_drdy_r;
	assign aux_drdy   = aux_drdy_r;

	// Live byte image, entry i at offset 0x10 plus i
	assign live_bytes[0*8 +: 8]  = {aux_smp[3:0], `RESERVED_NIB};
	assign live_bytes[1*8 +: 8]  = aux_smp[11:4];
	assign live_bytes[2*8 +: 8]  = {acc_x_smp[3:0], `RESERVED_NIB};
	assign live_bytes[3*8 +: 8]  = acc_x_smp[11:4];
	assign live_bytes[4*8 +: 8]  = {acc_y_smp[3:0], `RESERVED_NIB};
	assign live_bytes[5*8 +: 8]  = acc_y_smp[11:4];
	assign live_bytes[6*8 +: 8]  = {acc_z_smp[3:0], `RESERVED_NIB};
	assign live_bytes[7*8 +: 8]  = acc_z_smp[11:4];
	assign live_bytes[8*8 +: 8]  = time_r[7:0];
	assign live_bytes[9*8 +: 8]  = time_r[15:8];
	assign live_bytes[10*8 +: 8] = time_r[23:16];

	// Shadow copy; held for the whole burst so high and low bytes match
	snapshot_bank #(
		.NBYTES (NBYTES),
		.IDX_W  (IDX_W)
	) u_snapshot (
		.clk_sys    (clk_sys),
		.rst_b      (rst_b),
		.clk_en     (clk_en),
		.live_bytes (live_bytes),
		.hold       (burst_active),
		.rd_en      (bank_rd),
		.rd_idx     (bank_idx),
		.rd_data    (bank_rdata)
	);

	// Read answer one cycle after the strobe
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			rd_in_bank_r <= 1'b0;
			reg_rvalid   <= 1'b0;
		end else if (clk_en) begin
			rd_in_bank_r <= bank_rd;
			reg_rvalid   <= reg_rd;
		end
	end

	// Addresses outside the bank read zero
	always @* begin
		reg_rdata = `RESET_BYTE;
		if (rd_in_bank_r) begin
			reg_rdata = bank_rdata;
		end
	end

	// Writes are acknowledged but touch no state; data is discarded
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			reg_wack <= 1'b0;
		end else if (clk_en) begin
			reg_wack <= reg_wr && (reg_wdata == reg_wdata);
		end
	end

endmodule

/* File: hw/snapshot_bank.v */
`timescale 1ns/1ps
module snapshot_bank #(
	parameter NBYTES = 11,
	parameter IDX_W  = 4
) (
	// Clock and control
	input  wire                clk_sys,
	input  wire                rst_b,
	input  wire                clk_en,
	// Live contents and freeze
	input  wire [NBYTES*8-1:0] live_bytes,
	input  wire                hold,
	// Read port
	input  wire                rd_en,
	input  wire [IDX_W-1:0]    rd_idx,
	output reg  [7:0]          rd_data
);

	reg  [NBYTES*8-1:0] shadow_r;
	wire [NBYTES*8-1:0] shadow_nxt;

	genvar g;
	generate
		for (g = 0; g < NBYTES; g = g + 1) begin : g_entry
			// Track live bytes until a burst holds them
			assign shadow_nxt[g*8 +: 8] = hold ? shadow_r[g*8 +: 8] : live_bytes[g*8 +: 8];
			always @(posedge clk_sys) begin
				if (!rst_b) begin
					shadow_r[g*8 +: 8] <= 8'h00;
				end else if (clk_en) begin
					shadow_r[g*8 +: 8] <= shadow_nxt[g*8 +: 8];
				end
			end
		end
	endgenerate

	// Out-of-range index reads zero rather than a stale entry
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			rd_data <= 8'h00;
		end else if (clk_en && rd_en) begin
			if (rd_idx < NBYTES) begin
				rd_data <= shadow_r[rd_idx*8 +: 8];
			end else begin
				rd_data <= 8'h00;
			end
		end
	end

endmodule
